/* File: rtl/pbc_port_b_cfg.v */
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`include "pbc_port_b_map.vh"

module pbc_port_b_cfg #(
	parameter PINS = 8
) (
	input  wire            clk,
	input  wire            rst_n,
	input  wire            hsel,
	input  wire [31:0]     haddr,
	input  wire [1:0]      htrans,
	input  wire            hwrite,
	input  wire [2:0]      hsize,
	input  wire [31:0]     hwdata,
	input  wire            hready,
	output reg  [31:0]     hrdata,
	output reg             hreadyout,
	output reg             hresp,
	input  wire [PINS-1:0] pinIn,
	output reg  [PINS-1:0] pinOut,
	output reg  [PINS-1:0] pinOutEn,
	output reg  [PINS-1:0] pullEnable,
	output reg  [PINS-1:0] slewLimitEnable,
	output reg  [PINS-1:0] driveStrengthHigh,
	output reg  [PINS-1:0] inputFilterEnable
);
	localparam [1:0] PHASE_IDLE  = 2'h0;
	localparam [1:0] PHASE_WRITE = 2'h1;
	localparam [1:0] PHASE_READ  = 2'h2;
	localparam [2:0] IDX_DATA    = 3'h0;
	localparam [2:0] IDX_DIR     = 3'h1;
	localparam [2:0] IDX_PULL    = 3'h2;
	localparam [2:0] IDX_SLEW    = 3'h3;
	localparam [2:0] IDX_DRIVE   = 3'h4;
	localparam [2:0] IDX_FILTER  = 3'h5;
	localparam [2:0] IDX_NONE    = 3'h7;

	// Bus phase tracking
	reg  [1:0]      phase_reg;
	reg  [1:0]      phase_next;
	reg  [2:0]      index_reg;
	reg  [2:0]      index_next;
	reg  [2:0]      addrIndex;
	reg  [5:0]      wrStrobe;
	reg  [31:0]     hrdata_next;
	reg             hreadyout_next;
	reg             hresp_next;
	wire            wrLatch;
	// Pad control next values
	wire [PINS-1:0] pinOut_next;
	wire [PINS-1:0] pinOutEn_next;
	wire [PINS-1:0] pullEnable_next;
	wire [PINS-1:0] slewLimitEnable_next;
	wire [PINS-1:0] driveStrengthHigh_next;
	wire [PINS-1:0] inputFilterEnable_next;
	genvar          pinIdx;
	reg  [PINS-1:0] portDataLatch_reg;
	wire [PINS-1:0] pinSync;
	wire [PINS-1:0] pinDirectionBits;
	wire [PINS-1:0] pullDeviceEnableBits;
	wire [PINS-1:0] slewLimitEnableBits;
	wire [PINS-1:0] driveStrengthBits;
	wire [PINS-1:0] inputFilterEnableBits;
	wire            addrPhase;
	wire            wrDir;
	wire            wrPull;
	wire            wrSlew;
	wire            wrDrive;
	wire            wrFilter;
	reg  [PINS-1:0] rdSel;
	wire [PINS-1:0] dataView;
	reg  [PINS-1:0] portDataLatch_next;

	assign addrPhase = hsel && hready && htrans[1];

	// Offset to register index; unmapped offsets read 0 and drop writes
	always @* begin
		case (haddr[7:0])
		`PBC_OFS_DATA:   addrIndex = IDX_DATA;
		`PBC_OFS_DIR:    addrIndex = IDX_DIR;
		`PBC_OFS_PULL:   addrIndex = IDX_PULL;
		`PBC_OFS_SLEW:   addrIndex = IDX_SLEW;
		`PBC_OFS_DRIVE:  addrIndex = IDX_DRIVE;
		`PBC_OFS_FILTER: addrIndex = IDX_FILTER;
		default:         addrIndex = IDX_NONE;
		endcase
	end

	// Data phase follows an accepted address phase by one cycle
	always @* begin
		phase_next = phase_reg;
		index_next = index_reg;
		if (hready) begin
			index_next = addrIndex;
			case (phase_reg)
			PHASE_IDLE: begin
				if (addrPhase) begin
					phase_next = hwrite ? PHASE_WRITE : PHASE_READ;
				end else begin
					phase_next = PHASE_IDLE;
				end
			end
			PHASE_WRITE: begin
				if (addrPhase) begin
					phase_next = hwrite ? PHASE_WRITE : PHASE_READ;
				end else begin
					phase_next = PHASE_IDLE;
				end
			end
			PHASE_READ: begin
				if (addrPhase) begin
					phase_next = hwrite ? PHASE_WRITE : PHASE_READ;
				end else begin
					phase_next = PHASE_IDLE;
				end
			end
			default: begin
				phase_next = PHASE_IDLE;
			end
			endcase
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= PHASE_IDLE;
			index_reg <= IDX_NONE;
		end else begin
			phase_reg <= phase_next;
			index_reg <= index_next;
		end
	end

	// One strobe per register, only in a write data phase
	always @* begin
		wrStrobe = 6'h00;
		if (phase_reg == PHASE_WRITE) begin
			case (index_reg)
			IDX_DATA:   wrStrobe = 6'h01;
			IDX_DIR:    wrStrobe = 6'h02;
			IDX_PULL:   wrStrobe = 6'h04;
			IDX_SLEW:   wrStrobe = 6'h08;
			IDX_DRIVE:  wrStrobe = 6'h10;
			IDX_FILTER: wrStrobe = 6'h20;
			default:    wrStrobe = 6'h00;
			endcase
		end
	end

	assign wrLatch  = wrStrobe[0];
	assign wrDir    = wrStrobe[1];
	assign wrPull   = wrStrobe[2];
	assign wrSlew   = wrStrobe[3];
	assign wrDrive  = wrStrobe[4];
	assign wrFilter = wrStrobe[5];

	pbc_sync2 #(.WIDTH(PINS)) uPinSync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (pinIn),
		.syncOut (pinSync)
	);

	pbc_cfg_reg #(.WIDTH(PINS), .RESET_VAL(`PBC_RST_DIR)) uDir (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrDir),
		.wrData (hwdata[PINS-1:0]),
		.value  (pinDirectionBits)
	);

	pbc_cfg_reg #(.WIDTH(PINS), .RESET_VAL(`PBC_RST_PULL)) uPull (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrPull),
		.wrData (hwdata[PINS-1:0]),
		.value  (pullDeviceEnableBits)
	);

	pbc_cfg_reg #(.WIDTH(PINS), .RESET_VAL(`PBC_RST_SLEW)) uSlew (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrSlew),
		.wrData (hwdata[PINS-1:0]),
		.value  (slewLimitEnableBits)
	);

	pbc_cfg_reg #(.WIDTH(PINS), .RESET_VAL(`PBC_RST_DRIVE)) uDrive (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrDrive),
		.wrData (hwdata[PINS-1:0]),
		.value  (driveStrengthBits)
	);

	pbc_cfg_reg #(.WIDTH(PINS), .RESET_VAL(`PBC_RST_FILTER)) uFilter (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrFilter),
		.wrData (hwdata[PINS-1:0]),
		.value  (inputFilterEnableBits)
	);

	// Latch takes every bit whatever the direction
	always @* begin
		portDataLatch_next = portDataLatch_reg;
		if (wrLatch) begin
			portDataLatch_next = hwdata[PINS-1:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			portDataLatch_reg <= `PBC_RST_DATA;
		end else begin
			portDataLatch_reg <= portDataLatch_next;
		end
	end

	// Per-pin data view: latch for outputs, live pin for inputs
	generate
		for (pinIdx = 0; pinIdx < PINS; pinIdx = pinIdx + 1) begin : gView
			assign dataView[pinIdx] = pinDirectionBits[pinIdx] ?
				portDataLatch_reg[pinIdx] : pinSync[pinIdx];
		end
	endgenerate

	// Per-pin pad controls, each gated by that pin's direction except the input filter
	generate
		for (pinIdx = 0; pinIdx < PINS; pinIdx = pinIdx + 1) begin : gPad
			assign pinOut_next[pinIdx] = pinDirectionBits[pinIdx] &
				portDataLatch_reg[pinIdx];
			assign pinOutEn_next[pinIdx] =
				pinDirectionBits[pinIdx];
			assign pullEnable_next[pinIdx] = pullDeviceEnableBits[pinIdx] &
				~pinDirectionBits[pinIdx];
			assign slewLimitEnable_next[pinIdx] = slewLimitEnableBits[pinIdx] &
				pinDirectionBits[pinIdx];
			assign driveStrengthHigh_next[pinIdx] = driveStrengthBits[pinIdx] &
				pinDirectionBits[pinIdx];
			assign inputFilterEnable_next[pinIdx] =
				inputFilterEnableBits[pinIdx];
		end
	endgenerate

	// Read mux by register index
	always @* begin
		case (addrIndex)
		IDX_DATA:   rdSel = dataView;
		IDX_DIR:    rdSel = pinDirectionBits;
		IDX_PULL:   rdSel = pullDeviceEnableBits;
		IDX_SLEW:   rdSel = slewLimitEnableBits;
		IDX_DRIVE:  rdSel = driveStrengthBits;
		IDX_FILTER: rdSel = inputFilterEnableBits;
		default:    rdSel = {PINS{1'b0}};
		endcase
	end

	// Zero-wait slave, always OKAY; read data held until the next read
	always @* begin
		hreadyout_next = 1'b1;
		hresp_next     = 1'b0;
		hrdata_next    = hrdata;
		if (addrPhase && !hwrite) begin
			hrdata_next = {{(32-PINS){1'b0}}, rdSel};
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= hrdata_next;
			hreadyout <= hreadyout_next;
			hresp     <= hresp_next;
		end
	end

	// Pad controls follow the direction of each pin, except the input filter
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinOut            <= {PINS{1'b0}};
			pinOutEn          <= {PINS{1'b0}};
			pullEnable        <= {PINS{1'b0}};
			slewLimitEnable   <= {PINS{1'b0}};
			driveStrengthHigh <= {PINS{1'b0}};
			inputFilterEnable <= {PINS{1'b0}};
		end else begin
			pinOut            <= pinOut_next;
			pinOutEn          <= pinOutEn_next;
			pullEnable        <= pullEnable_next;
			slewLimitEnable   <= slewLimitEnable_next;
			driveStrengthHigh <= driveStrengthHigh_next;
			inputFilterEnable <= inputFilterEnable_next;
		end
	end
endmodule // pbc_port_b_cfg

/* File: rtl/pbc_port_b_map.vh */
// Contract
// - A pin whose direction bit is 0 has its output driver off and data reads return the live pin level.
// - A pin whose direction bit is 1 has its output driver on and data reads return its output latch bit.
// - The direction register is eight bits, read/write, reset to all zeros so every pin starts as input.
// - One pull-enable bit per pin, bits 7 to 0, where 1 turns the pin's pull device on and 0 off.
// - A pin set as output ignores its pull-enable bit and keeps its pull device off.
// - One slew-limit bit per pin, bits 7 to 0, reset to zero, 1 enables slew limiting, no effect on inputs.
// - One drive-strength bit per pin, 0 low drive and 1 high drive, no effect on inputs.
// - One input-filter bit per pin, bits 7 to 0, reset to zero, 1 enables the pin's low-pass filter.
// - The output latch takes writes to all bits regardless of direction, drives only output pins, reset clears it.
`ifndef PBC_PORT_B_MAP_VH
`define PBC_PORT_B_MAP_VH

`define PBC_OFS_DATA      8'h00
`define PBC_OFS_DIR       8'h04
`define PBC_OFS_PULL      8'h08
`define PBC_OFS_SLEW      8'h0C
`define PBC_OFS_DRIVE     8'h10
`define PBC_OFS_FILTER    8'h14

`define PBC_RST_DATA      8'h00
`define PBC_RST_DIR       8'h00
`define PBC_RST_PULL      8'h00
`define PBC_RST_SLEW      8'h00
`define PBC_RST_DRIVE     8'h00
`define PBC_RST_FILTER    8'h00

`define PBC_HTRANS_NONSEQ 2'h2
`define PBC_HSIZE_WORD    3'h2

`endif

/* File: rtl/pbc_sync2.v */
`timescale 1ns/1ns
// Two-stage synchroniser for the pin levels
module pbc_sync2 #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule // pbc_sync2

/* File: rtl/pbc_cfg_reg.v */
`timescale 1ns/1ns
// One writable configuration byte
module pbc_cfg_reg #(
	parameter       WIDTH     = 8,
	parameter [7:0] RESET_VAL = 8'h00
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             wrEn,
	input  wire [WIDTH-1:0] wrData,
	output wire [WIDTH-1:0] value
);
	reg [WIDTH-1:0] value_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_reg <= RESET_VAL[WIDTH-1:0];
		end else if (wrEn) begin
			value_reg <= wrData;
		end
	end

	assign value = value_reg;
endmodule // pbc_cfg_reg

/* File: testbench/pbc_port_b_chk.sv */
`timescale 1ns/1ns
module pbc_port_b_chk #(
	parameter PINS = 8
) (
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            hsel,
	input wire logic [31:0]     haddr,
	input wire logic [1:0]      htrans,
	input wire logic            hwrite,
	input wire logic [31:0]     hwdata,
	input wire logic            hready,
	input wire logic [31:0]     hrdata,
	input wire logic            hreadyout,
	input wire logic            hresp,
	input wire logic [PINS-1:0] pinOut,
	input wire logic [PINS-1:0] pinOutEn,
	input wire logic [PINS-1:0] pullEnable,
	input wire logic [PINS-1:0] slewLimitEnable,
	input wire logic [PINS-1:0] driveStrengthHigh,
	input wire logic [PINS-1:0] inputFilterEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic go = hsel && hready && htrans[1];
	a_out_gated: assert property ((pinOut & ~pinOutEn) == 0)
		else $error("input pin driven");
	a_pull_off: assert property ((pullEnable & pinOutEn) == 0)
		else $error("pull on output");
	a_slew_gated: assert property ((slewLimitEnable & ~pinOutEn) == 0)
		else $error("slew on input");
	a_drive_gated: assert property ((driveStrengthHigh & ~pinOutEn) == 0)
		else $error("drive on input");
	a_dir_write: assert property (go && hwrite && haddr[7:0] == 8'h04 |->
		##3 pinOutEn == $past(hwdata[PINS-1:0], 2)) else $error("direction lost");
	a_filter_write: assert property (go && hwrite && haddr[7:0] == 8'h14 |->
		##3 inputFilterEnable == $past(hwdata[PINS-1:0], 2)) else $error("filter lost");
	a_pull_write: assert property (go && hwrite && haddr[7:0] == 8'h08 |->
		##3 pullEnable == ($past(hwdata[PINS-1:0], 2) & ~pinOutEn)) else $error("pull lost");
	a_read_upper: assert property (go && !hwrite |=> hrdata[31:8] == 0)
		else $error("upper read bits set");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
	cover property (go && hwrite);
	cover property (go && !hwrite);
	cover property (pullEnable != 0);
endmodule // pbc_port_b_chk

/* File: testbench/pbc_pad_model.sv */
`timescale 1ns/1ns
module pbc_pad_model (
	input wire logic [7:0]  pinOut,
	input wire logic [7:0]  pinOutEn,
	input wire logic [7:0]  pullEnable,
	input wire logic [7:0]  extLevel,
	input wire logic [7:0]  extDrive,
	output wire logic [7:0] pinIn
);
	// Driven, else external, else pulled up, else floating opposite
	assign pinIn = pinOutEn & pinOut | ~pinOutEn & (extDrive & extLevel
		| ~extDrive & (pullEnable | ~extLevel));
endmodule // pbc_pad_model

/* File: testbench/port_b_pin_config_bench.sv */
`timescale 1ns/1ns
module port_b_pin_config_bench;
	logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  pinIn, pinOut, pinOutEn, pullEnable, slewLimitEnable, driveStrengthHigh;
	logic [7:0]  inputFilterEnable, extLevel = 8'h00, extDrive = 8'hFF;
	int          mismatches = 0, comparisons = 0;
	initial forever #10 clk = ~clk;
	pbc_port_b_cfg u_pbc_port_b_cfg (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pinIn, .pinOut, .pinOutEn,
		.pullEnable, .slewLimitEnable, .driveStrengthHigh, .inputFilterEnable);
	pbc_pad_model u_pbc_pad_model (.pinOut, .pinOutEn, .pullEnable, .extLevel, .extDrive, .pinIn);
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	task give_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			give_verdict;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask
	task t_reset;
		for (int a = 0; a < 28; a += 4) begin
			xfer(1'b0, a[7:0], 32'h0);
			chk(q, 32'h0);
		end
		chk(pinOutEn, 32'h0);
		chk(pinOut, 32'h0);
		chk(pullEnable, 32'h0);
		chk(slewLimitEnable | driveStrengthHigh, 32'h0);
		chk(inputFilterEnable, 32'h0);
		xfer(1'b1, 8'h04, 32'hFF);
		repeat (2) @(posedge clk);
		#1;
		chk(pinOutEn, 32'hFF);
		chk(pinOut, 32'h0);
		xfer(1'b1, 8'h04, 32'h0);
	endtask
	task t_config;
		xfer(1'b1, 8'h08, 32'hFF);
		xfer(1'b1, 8'h0C, 32'hFF);
		xfer(1'b1, 8'h10, 32'hFF);
		xfer(1'b1, 8'h14, 32'hA5);
		xfer(1'b1, 8'h00, 32'h3C);
		xfer(1'b1, 8'h04, 32'h0F);
		repeat (2) @(posedge clk);
		#1;
		chk(pinOutEn, 8'h0F);
		chk(pullEnable, 8'hF0);
		chk(slewLimitEnable, 8'h0F);
		chk(driveStrengthHigh, 8'h0F);
		chk(inputFilterEnable, 8'hA5);
		chk(pinOut, 8'h0C);
		xfer(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0F);
	endtask
	task t_pins;
		extDrive <= 8'hF0;
		extLevel <= 8'h50;
		repeat (4) @(posedge clk);
		xfer(1'b0, 8'h00, 32'h0);
		chk(q, 32'h5C);
		extDrive <= 8'h00;
		extLevel <= 8'hFF;
		repeat (4) @(posedge clk);
		xfer(1'b0, 8'h00, 32'h0);
		chk(q, 32'hFC);
		xfer(1'b1, 8'h04, 32'hF0);
		repeat (2) @(posedge clk);
		#1;
		chk(pinOut, 8'h30);
		chk(pullEnable, 8'h0F);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_config;
		t_pins;
		give_verdict;
	end
endmodule // port_b_pin_config_bench
bind pbc_port_b_cfg pbc_port_b_chk #(.PINS(PINS)) u_pbc_port_b_chk (.clk, .rst_n, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pinOut, .pinOutEn,
	.pullEnable, .slewLimitEnable, .driveStrengthHigh, .inputFilterEnable);
